// File: src/scch_condition_handler.v
`timescale 1ns/1ps
`default_nettype none
`include "scch_map.vh"
module scch_condition_handler #(
	parameter OWN_ID = 3'd7,
	parameter UA_QUAL = 8'h00
) (
	// Clock and reset
	input wire clk_sys,
	input wire reset,
	// Command from bus front end
	input wire cmdValid,
	input wire [7:0] cmdOpcode,
	input wire [2:0] cmdInitiator,
	input wire cmdIdKnown,
	input wire cmdBusy,
	input wire [15:0] cmdElemAddr,
	input wire [1:0] cmdElemSel,
	// Events
	input wire uaEvent,
	input wire [7:0] uaCode,
	input wire hwFailValid,
	input wire hwFailUnrecov,
	input wire [7:0] hwFailQual,
	input wire ifaceFault,
	// Answer
	output reg respValid,
	output reg [7:0] respStatus,
	output reg [3:0] respCdbLen,
	output reg [3:0] respSenseKey,
	output reg [7:0] respAsc,
	output reg [7:0] respAscq,
	output reg motionStart,
	output reg [7:0] respOpcode,
	// Element addresses, display, fault flag and command ready
	output reg [15:0] addrMech,
	output reg [15:0] addrSlot,
	output reg [15:0] addrTape,
	output reg [7:0] displayCode,
	output reg faultLatched,
	output wire cmdReady
);
	reg [7:0] uaPend;
	reg [7:0] uaReported;
	reg [7:0] uaAsc;
	reg [3:0] senseKey [0:7];
	reg [7:0] senseAsc [0:7];
	reg [7:0] senseAscq [0:7];
	reg rsvHeld;
	reg [2:0] rsvOwner;
	reg [7:0] hwQual;
	reg ifaceDead;
	wire [2:0] idx;
	wire isMotion;
	wire isTur;
	wire isInfo;
	wire known;
	integer i;

	function [3:0] cdb_len;
		input [7:0] op;
		begin
			case (op)
				`SCCH_OP_PARK, `SCCH_OP_LOG: cdb_len = `SCCH_LEN_10;
				`SCCH_OP_MOVE, `SCCH_OP_RES: cdb_len = `SCCH_LEN_12;
				`SCCH_OP_TUR, `SCCH_OP_RSENSE, `SCCH_OP_INITES, `SCCH_OP_INQ,
				`SCCH_OP_PSET, `SCCH_OP_RSV, `SCCH_OP_REL, `SCCH_OP_PREP,
				`SCCH_OP_RDIAG, `SCCH_OP_SDIAG: cdb_len = `SCCH_LEN_6;
				default: cdb_len = 4'h0;
			endcase
		end
	endfunction

	function motion_op;
		input [7:0] op;
		begin
			motion_op = (op == `SCCH_OP_MOVE) || (op == `SCCH_OP_PARK) ||
				(op == `SCCH_OP_INITES) || (op == `SCCH_OP_SDIAG);
		end
	endfunction

	assign idx = cmdIdKnown ? cmdInitiator : OWN_ID;
	assign isMotion = motion_op(cmdOpcode);
	assign isTur = cmdOpcode == `SCCH_OP_TUR;
	assign isInfo = (cmdOpcode == `SCCH_OP_INQ) ||
		(cmdOpcode == `SCCH_OP_RSENSE);
	assign known = cdb_len(cmdOpcode) != 4'h0;
	// stop taking commands only on interface fault
	assign cmdReady = !ifaceDead;

	always @(posedge clk_sys) begin
		if (reset) begin
			uaPend <= 8'hFF;
			uaReported <= 8'h00;
			uaAsc <= `SCCH_ASC_UATTN;
			for (i = 0; i < 8; i = i + 1) begin
				senseKey[i] <= `SCCH_SK_NONE;
				senseAsc[i] <= `SCCH_ASC_NONE;
				senseAscq[i] <= 8'h00;
			end
			rsvHeld <= 1'b0;
			rsvOwner <= 3'd0;
			hwQual <= 8'h00;
			ifaceDead <= 1'b0;
			faultLatched <= 1'b0;
			displayCode <= 8'h00;
			respValid <= 1'b0;
			respStatus <= `SCCH_ST_GOOD;
			respCdbLen <= 4'h0;
			respSenseKey <= `SCCH_SK_NONE;
			respAsc <= `SCCH_ASC_NONE;
			respAscq <= 8'h00;
			respOpcode <= 8'h00;
			motionStart <= 1'b0;
			addrMech <= `SCCH_ADDR_MECH;
			addrSlot <= `SCCH_ADDR_SLOT;
			addrTape <= `SCCH_ADDR_TAPE;
		end else begin
			respValid <= 1'b0;
			motionStart <= 1'b0;
			if (ifaceFault)
				ifaceDead <= 1'b1;
			// motion failure sets hardware error sense
			if (hwFailValid) begin
				senseKey[idx] <= `SCCH_SK_HWERR;
				senseAsc[idx] <= `SCCH_ASC_HWERR;
				senseAscq[idx] <= hwFailQual;
				respValid <= 1'b1;
				respStatus <= `SCCH_ST_CHECK;
				respSenseKey <= `SCCH_SK_HWERR;
				respAsc <= `SCCH_ASC_HWERR;
				respAscq <= hwFailQual;
				if (hwFailUnrecov) begin
					faultLatched <= 1'b1;
					hwQual <= hwFailQual;
					displayCode <= hwFailQual;
				end
			end else if (cmdValid && !ifaceDead) begin
				respValid <= 1'b1;
				respOpcode <= cmdOpcode;
				respCdbLen <= cdb_len(cmdOpcode);
				respSenseKey <= senseKey[idx];
				respAsc <= senseAsc[idx];
				respAscq <= senseAscq[idx];
				respStatus <= `SCCH_ST_GOOD;
				if (cmdBusy && !isInfo) begin
					respStatus <= `SCCH_ST_BUSY;
				end else if (uaPend[idx] && !isInfo) begin
					respStatus <= `SCCH_ST_CHECK;
					uaReported[idx] <= 1'b1;
					senseKey[idx] <= `SCCH_SK_UATTN;
					senseAsc[idx] <= uaAsc;
					senseAscq[idx] <= UA_QUAL;
					respSenseKey <= `SCCH_SK_UATTN;
					respAsc <= uaAsc;
					respAscq <= UA_QUAL;
					if (uaReported[idx]) begin
						uaPend[idx] <= 1'b0;
						uaReported[idx] <= 1'b0;
						senseKey[idx] <= `SCCH_SK_NONE;
						senseAsc[idx] <= `SCCH_ASC_NONE;
						senseAscq[idx] <= 8'h00;
						respStatus <= `SCCH_ST_GOOD;
					end
				end else if (!known) begin
					respStatus <= `SCCH_ST_CHECK;
					senseKey[idx] <= `SCCH_SK_ILLEGAL;
					senseAsc[idx] <= `SCCH_ASC_BADOP;
					senseAscq[idx] <= 8'h00;
				end else if (faultLatched && (isMotion || isTur)) begin
					respStatus <= `SCCH_ST_CHECK;
					senseKey[idx] <= `SCCH_SK_HWERR;
					senseAsc[idx] <= `SCCH_ASC_HWERR;
					senseAscq[idx] <= hwQual;
					respSenseKey <= `SCCH_SK_HWERR;
					respAsc <= `SCCH_ASC_HWERR;
					respAscq <= hwQual;
				end else if (cmdOpcode == `SCCH_OP_RSENSE) begin
					senseKey[idx] <= `SCCH_SK_NONE;
					senseAsc[idx] <= `SCCH_ASC_NONE;
					senseAscq[idx] <= 8'h00;
					if (uaReported[idx] && !uaEvent) begin
						uaPend[idx] <= 1'b0;
						uaReported[idx] <= 1'b0;
					end
				end else if (cmdOpcode == `SCCH_OP_INQ) begin
					respStatus <= `SCCH_ST_GOOD;
				end else if ((cmdOpcode == `SCCH_OP_RSV ||
					cmdOpcode == `SCCH_OP_MOVE) && rsvHeld &&
					rsvOwner != idx) begin
					respStatus <= `SCCH_ST_CONFLICT;
				end else begin
					senseKey[idx] <= `SCCH_SK_NONE;
					senseAsc[idx] <= `SCCH_ASC_NONE;
					senseAscq[idx] <= 8'h00;
					if (isMotion)
						motionStart <= 1'b1;
					if (cmdOpcode == `SCCH_OP_RSV) begin
						rsvHeld <= 1'b1;
						rsvOwner <= idx;
					end
					if (cmdOpcode == `SCCH_OP_REL && rsvOwner == idx)
						rsvHeld <= 1'b0;
					if (cmdOpcode == `SCCH_OP_PSET) begin
						case (cmdElemSel)
							2'd0: addrMech <= cmdElemAddr;
							2'd1: addrSlot <= cmdElemAddr;
							2'd2: addrTape <= cmdElemAddr;
							default: addrMech <= addrMech;
						endcase
					end
				end
			end
			if (uaEvent) begin
				uaPend <= 8'hFF;
				uaReported <= 8'h00;
				uaAsc <= uaCode;
			end
		end
	end
endmodule
`default_nettype wire

// File: src/scch_map.vh
`ifndef SCCH_MAP_VH
`define SCCH_MAP_VH
// Opcodes
`define SCCH_OP_TUR 8'h00
`define SCCH_OP_RSENSE 8'h03
`define SCCH_OP_INITES 8'h07
`define SCCH_OP_INQ 8'h12
`define SCCH_OP_PSET 8'h15
`define SCCH_OP_RSV 8'h16
`define SCCH_OP_REL 8'h17
`define SCCH_OP_PREP 8'h1A
`define SCCH_OP_RDIAG 8'h1C
`define SCCH_OP_SDIAG 8'h1D
`define SCCH_OP_PARK 8'h2B
`define SCCH_OP_LOG 8'h4D
`define SCCH_OP_MOVE 8'hA5
`define SCCH_OP_RES 8'hB8
// Status bytes
`define SCCH_ST_GOOD 8'h00
`define SCCH_ST_CHECK 8'h02
`define SCCH_ST_BUSY 8'h08
`define SCCH_ST_CONFLICT 8'h18
// Sense keys
`define SCCH_SK_NONE 4'h0
`define SCCH_SK_HWERR 4'h4
`define SCCH_SK_ILLEGAL 4'h5
`define SCCH_SK_UATTN 4'h6
// Additional sense codes
`define SCCH_ASC_NONE 8'h00
`define SCCH_ASC_BADOP 8'h20
`define SCCH_ASC_UATTN 8'h29
`define SCCH_ASC_HWERR 8'h40
// Descriptor lengths
`define SCCH_LEN_6 4'h6
`define SCCH_LEN_10 4'hA
`define SCCH_LEN_12 4'hC
// Default element addresses
`define SCCH_ADDR_MECH 16'h0000
`define SCCH_ADDR_SLOT 16'h000A
`define SCCH_ADDR_TAPE 16'h0050
`endif

// File: bench/scch_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module scch_host_model (
	// Bus side
	input wire logic clk_sys,
	output logic cmdValid,
	output logic [7:0] cmdOpcode,
	output logic [2:0] cmdInitiator,
	output logic cmdIdKnown
);
	initial begin
		cmdValid = 1'b0;
		cmdOpcode = 8'h00;
		cmdInitiator = 3'h0;
		cmdIdKnown = 1'b1;
	end
	// Own id rides with every command
	task send(input logic [7:0] op, input logic [2:0] id);
		@(posedge clk_sys) #1;
		cmdValid = 1'b1;
		cmdOpcode = op;
		cmdInitiator = id;
		@(posedge clk_sys) #1;
		cmdValid = 1'b0;
		cmdOpcode = ~op;
	endtask
endmodule
`default_nettype wire

// File: bench/scch_condition_handler_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module scch_checker (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Inputs, plus the cmdReady output
	input wire logic cmdValid,
	input wire logic cmdReady,
	input wire logic [7:0] cmdOpcode,
	input wire logic hwFailValid,
	input wire logic hwFailUnrecov,
	input wire logic ifaceFault,
	// Outputs
	input wire logic respValid,
	input wire logic [7:0] respStatus,
	input wire logic [3:0] respSenseKey,
	input wire logic motionStart,
	input wire logic faultLatched
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic take;
	assign take = cmdValid && cmdReady && !hwFailValid;
	one_answer_a: assert property (take |=> respValid)
		else $error("answer missing");
	no_spur_a: assert property (!take && !hwFailValid |=> !respValid)
		else $error("answer without command");
	bad_op_a: assert property (take && cmdOpcode == 8'h08 |=>
		respStatus == 8'h02) else $error("bad opcode accepted");
	fault_latch_a: assert property (hwFailValid && hwFailUnrecov |=>
		faultLatched) else $error("fault not kept");
	no_motion_a: assert property (faultLatched |-> !motionStart)
		else $error("motion after fault");
	tur_fault_a: assert property (take && faultLatched &&
		cmdOpcode == 8'h00 |=> respStatus == 8'h02 && respSenseKey == 4'h4)
		else $error("ready check after fault");
	iface_dead_a: assert property (ifaceFault |=> !cmdReady [*4])
		else $error("ready after interface fault");
	motion_good_a: assert property (motionStart |->
		respValid && respStatus == 8'h00) else $error("motion not good");
	cover property (take && faultLatched);
	cover property (motionStart);
	cover property (ifaceFault);
endmodule
bind scch_condition_handler scch_checker chk_u (.clk_sys(clk_sys),
	.reset(reset), .cmdValid(cmdValid), .cmdReady(cmdReady),
	.cmdOpcode(cmdOpcode), .hwFailValid(hwFailValid),
	.hwFailUnrecov(hwFailUnrecov), .ifaceFault(ifaceFault),
	.respValid(respValid), .respStatus(respStatus),
	.respSenseKey(respSenseKey), .motionStart(motionStart),
	.faultLatched(faultLatched));
`default_nettype wire

// File: bench/tb_scch_condition_handler.sv
`timescale 1ns/1ps
`default_nettype none
module tb_scch_condition_handler;
	logic clk_sys, reset, hwFailValid, ifaceFault, cmdValid, cmdIdKnown;
	logic uaEvent;
	logic respValid, motionStart, faultLatched, cmdReady;
	logic [2:0] cmdInitiator;
	logic [3:0] respSenseKey, respCdbLen;
	logic [7:0] cmdOpcode, respStatus, displayCode;
	logic [15:0] addrMech, addrSlot, addrTape;
	int err_total, check_count;
	logic [7:0] ops [14] = '{8'h00, 8'h03, 8'h07, 8'h12, 8'h15, 8'h16,
		8'h17, 8'h1A, 8'h1C, 8'h1D, 8'h2B, 8'h4D, 8'hA5, 8'hB8};
	scch_host_model host_u (.clk_sys(clk_sys), .cmdValid(cmdValid),
		.cmdOpcode(cmdOpcode), .cmdInitiator(cmdInitiator),
		.cmdIdKnown(cmdIdKnown));
	scch_condition_handler dut_u (.clk_sys(clk_sys), .reset(reset),
		.cmdValid(cmdValid), .cmdOpcode(cmdOpcode),
		.cmdInitiator(cmdInitiator), .cmdIdKnown(cmdIdKnown),
		.cmdBusy(1'b0), .cmdElemAddr(16'h0123), .cmdElemSel(2'h1),
		.uaEvent(uaEvent), .uaCode(8'h00), .hwFailValid(hwFailValid),
		.hwFailUnrecov(hwFailValid), .hwFailQual(8'h5C),
		.ifaceFault(ifaceFault), .respValid(respValid),
		.respStatus(respStatus), .respCdbLen(respCdbLen),
		.respSenseKey(respSenseKey), .respAsc(), .respAscq(),
		.motionStart(motionStart), .respOpcode(), .addrMech(addrMech),
		.addrSlot(addrSlot), .addrTape(addrTape),
		.displayCode(displayCode), .faultLatched(faultLatched),
		.cmdReady(cmdReady));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task cmd(input logic [7:0] op, input logic [2:0] id, input logic [7:0] st);
		host_u.send(op, id);
		chk(respValid, 1'b1);
		chk(respStatus, st);
	endtask
	task t_ua;
		cmd(8'h12, 3'd1, 8'h00);
		cmd(8'h1A, 3'd1, 8'h02);
		chk(respSenseKey, 4'h6);
		cmd(8'h1A, 3'd1, 8'h00);
		cmd(8'h03, 3'd2, 8'h00);
		cmd(8'h00, 3'd2, 8'h02);
		cmd(8'h03, 3'd2, 8'h00);
		chk(respSenseKey, 4'h6);
		cmd(8'h03, 3'd2, 8'h00);
		chk(respSenseKey, 4'h0);
		// New attention replaces the old one for every initiator
		@(posedge clk_sys) #1 uaEvent = 1'b1;
		@(posedge clk_sys) #1 uaEvent = 1'b0;
		cmd(8'h1A, 3'd2, 8'h02);
		chk(respSenseKey, 4'h6);
		cmd(8'h1A, 3'd2, 8'h00);
		cmd(8'h1A, 3'd1, 8'h02);
		cmd(8'h1A, 3'd1, 8'h00);
	endtask
	task t_ops;
		chk(addrMech, 16'h0000);
		chk(addrTape, 16'h0050);
		foreach (ops[i]) begin
			cmd(ops[i], 3'd1, 8'h00);
			chk(respCdbLen, ops[i] > 8'hA0 ? 4'hC : ops[i] > 8'h20 ? 4'hA : 4'h6);
		end
		chk(addrSlot, 16'h0123);
		cmd(8'h08, 3'd1, 8'h02);
		cmd(8'h03, 3'd1, 8'h00);
		chk(respSenseKey, 4'h5);
	endtask
	task t_rsv;
		cmd(8'h16, 3'd1, 8'h00);
		cmd(8'h17, 3'd2, 8'h00);
		cmd(8'hA5, 3'd2, 8'h18);
		cmd(8'h17, 3'd1, 8'h00);
		cmd(8'hA5, 3'd2, 8'h00);
	endtask
	task t_fault;
		@(posedge clk_sys) #1 hwFailValid = 1'b1;
		@(posedge clk_sys) #1 hwFailValid = 1'b0;
		chk(faultLatched, 1'b1);
		chk(displayCode, 8'h5C);
		cmd(8'hA5, 3'd1, 8'h02);
		chk(respSenseKey, 4'h4);
		chk(motionStart, 1'b0);
		cmd(8'h00, 3'd1, 8'h02);
		cmd(8'h1A, 3'd1, 8'h00);
		cmd(8'h03, 3'd1, 8'h00);
		chk(respSenseKey, 4'h0);
		@(posedge clk_sys) #1 ifaceFault = 1'b1;
		@(posedge clk_sys) #1 ifaceFault = 1'b0;
		chk(cmdReady, 1'b0);
	endtask
	task test_done;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#20000;
		err_total++;
		test_done;
	end
	initial begin
		reset = 1'b1;
		hwFailValid = 1'b0;
		ifaceFault = 1'b0;
		uaEvent = 1'b0;
		repeat (6) @(posedge clk_sys);
		#1 reset = 1'b0;
		t_ua;
		t_ops;
		t_rsv;
		t_fault;
		test_done;
	end
endmodule
`default_nettype wire
